// ===== smbus_host_model.sv
`timescale 1ns/1ns
module smbus_host_model (
	// Clock
	input wire logic clk,
	// Bus pins
	output logic     scl,
	output logic     sda,
	input wire logic sda_line
);
	int nak_cnt;

	initial begin
		scl = 1'b1;
		sda = 1'b1;
		nak_cnt = 0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Data moves one cycle after the fall and is sampled late in the high
	// phase, so the device's synchronised acknowledge has time to settle
	task automatic bit_io(input logic b, output logic r);
		sda <= b;
		wt(4);
		scl <= 1'b1;
		wt(2);
		r = sda_line;
		wt(1);
		scl <= 1'b0;
		wt(1);
	endtask

	task automatic byte_out(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		if (r) nak_cnt++;
	endtask

	task automatic byte_in(output logic [7:0] d, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask

	task automatic start_c(input logic rep);
		if (rep) begin
			sda <= 1'b1;
			wt(4);
			scl <= 1'b1;
			wt(4);
		end
		sda <= 1'b0;
		wt(4);
		scl <= 1'b0;
		wt(1);
	endtask

	task automatic stop_c();
		sda <= 1'b0;
		wt(4);
		scl <= 1'b1;
		wt(4);
		sda <= 1'b1;
		wt(8);
	endtask

	// Write: thresholds as words, action byte as byte, clear as send byte
	task automatic wr(input logic [7:0] cmd, input logic [15:0] data, input logic [1:0] len);
		start_c(1'b0);
		byte_out({tfr_pkg::TARGET_ADDR, 1'b0});
		byte_out(cmd);
		if (len != tfr_pkg::LEN_SEND) byte_out(data[7:0]);
		if (len == tfr_pkg::LEN_WORD) byte_out(data[15:8]);
		stop_c();
	endtask

	task automatic rd(input logic [7:0] cmd, input logic [1:0] len, output logic [15:0] d);
		d = 16'h0000;
		start_c(1'b0);
		byte_out({tfr_pkg::TARGET_ADDR, 1'b0});
		byte_out(cmd);
		start_c(1'b1);
		byte_out({tfr_pkg::TARGET_ADDR, 1'b1});
		byte_in(d[7:0], len == tfr_pkg::LEN_BYTE);
		if (len == tfr_pkg::LEN_WORD) byte_in(d[15:8], 1'b1);
		stop_c();
	endtask
endmodule

// ===== smbus_target.sv
`timescale 1ns/1ns
module smbus_target (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_oe_n,
	// Completed write
	output logic             wr_valid,
	output logic [7:0]       wr_cmd,
	output logic [15:0]      wr_data,
	output logic [1:0]       wr_len,
	// Read data for the current command
	input  wire logic [15:0] rd_word
);
	logic [1:0]  scl_m_q, sda_m_q;
	logic        scl_s_q, sda_s_q, scl_p_q, sda_p_q;
	logic [7:0]  shift_q;
	logic [3:0]  bit_q;
	logic [2:0]  idx_q;
	logic        rd_q, hi_q, oe_n_q, wv_q;
	logic [7:0]  cmd_q;
	logic [15:0] data_q;
	logic [1:0]  len_q;
	tfr_pkg::bus_state_t st_q;

	wire start_c = scl_s_q && sda_p_q && !sda_s_q;
	wire stop_c  = scl_s_q && !sda_p_q && sda_s_q;
	wire rise    = scl_s_q && !scl_p_q;
	wire fall    = !scl_s_q && scl_p_q;
	wire addr_ok = shift_q[7:1] == tfr_pkg::TARGET_ADDR;
	wire [7:0] tx_byte = hi_q ? rd_word[15:8] : rd_word[7:0];

	// Pins cross three flops; the first stage feeds only the second
	always_ff @(posedge clk) begin
		scl_m_q <= {scl_m_q[0], scl_in};
		sda_m_q <= {sda_m_q[0], sda_in};
		scl_s_q <= scl_m_q[1];
		sda_s_q <= sda_m_q[1];
		scl_p_q <= scl_s_q;
		sda_p_q <= sda_s_q;
	end

	always_ff @(posedge clk) begin
		wv_q <= 1'b0;
		if (rst) begin
			st_q   <= tfr_pkg::BS_IDLE;
			oe_n_q <= 1'b1;
			bit_q  <= 4'h0;
			idx_q  <= 3'h0;
			rd_q   <= 1'b0;
			hi_q   <= 1'b0;
			shift_q <= 8'h00;
			cmd_q  <= 8'h00;
			data_q <= 16'h0000;
			len_q  <= 2'h0;
		end else if (start_c) begin
			st_q   <= tfr_pkg::BS_RX;
			oe_n_q <= 1'b1;
			bit_q  <= 4'h0;
			idx_q  <= 3'h0;
			hi_q   <= 1'b0;
		end else if (stop_c) begin
			st_q   <= tfr_pkg::BS_IDLE;
			oe_n_q <= 1'b1;
			if (!rd_q && idx_q >= 3'h2) begin
				wv_q  <= 1'b1;
				len_q <= 2'(idx_q - 3'h2);
			end
		end else begin
			unique case (st_q)
				tfr_pkg::BS_IDLE: ;
				tfr_pkg::BS_RX: begin
					if (rise && bit_q < 4'h8) begin
						shift_q <= {shift_q[6:0], sda_s_q};
						bit_q   <= bit_q + 4'h1;
					end else if (fall && bit_q == 4'h8) begin
						// Bytes past a word are refused with a nack
						if ((idx_q == 3'h0 && addr_ok) || (idx_q != 3'h0 && idx_q < 3'h4)) begin
							oe_n_q <= 1'b0;
							st_q   <= tfr_pkg::BS_ACK;
							idx_q  <= idx_q + 3'h1;
						end else begin
							st_q <= tfr_pkg::BS_IDLE;
						end
						if (idx_q == 3'h0)
							rd_q <= shift_q[0];
						if (idx_q == 3'h1)
							cmd_q <= shift_q;
						if (idx_q == 3'h2)
							data_q[7:0] <= shift_q;
						if (idx_q == 3'h3)
							data_q[15:8] <= shift_q;
					end
				end
				tfr_pkg::BS_ACK: begin
					if (fall) begin
						bit_q <= 4'h0;
						if (rd_q) begin
							shift_q <= tx_byte;
							oe_n_q  <= tx_byte[7];
							st_q    <= tfr_pkg::BS_TX;
						end else begin
							oe_n_q <= 1'b1;
							st_q   <= tfr_pkg::BS_RX;
						end
					end
				end
				tfr_pkg::BS_TX: begin
					if (fall) begin
						if (bit_q == 4'h7) begin
							oe_n_q <= 1'b1;
							st_q   <= tfr_pkg::BS_TXACK;
						end else begin
							shift_q <= {shift_q[6:0], 1'b0};
							oe_n_q  <= shift_q[6];
							bit_q   <= bit_q + 4'h1;
						end
					end
				end
				tfr_pkg::BS_TXACK: begin
					if (rise) begin
						// Low byte goes first; a nack ends the read
						hi_q <= ~hi_q;
						st_q <= sda_s_q ? tfr_pkg::BS_IDLE : tfr_pkg::BS_ACK;
					end
				end
			endcase
		end
	end

	assign sda_oe_n = oe_n_q;
	assign wr_valid = wv_q;
	assign wr_cmd   = cmd_q;
	assign wr_data  = data_q;
	assign wr_len   = len_q;
endmodule

// ===== temp_fault_response.sv
`timescale 1ns/1ns
module temp_fault_response (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	// Measurement and timing
	input  wire logic [15:0] temp_reading,
	input  wire logic [15:0] delay_unit_cycles,
	// On/off and clearing
	input  wire logic        ctrl_pin,
	input  wire logic        operation_on,
	input  wire logic        status_bit_clear,
	input  wire logic        other_fault_shutdown,
	// Status
	output logic             output_enable,
	output logic             ot_warning,
	output logic             ut_warning,
	output logic             ut_fault,
	output logic             fault_latched,
	output logic             restart_attempt
);

	logic        wr_valid;
	logic [7:0]  wr_cmd;
	logic [15:0] wr_data;
	logic [1:0]  wr_len;
	logic [15:0] rd_word;

	logic [15:0] ot_warn_q;
	logic [15:0] ut_warn_q;
	logic [15:0] ut_fault_lim_q;
	logic [7:0]  action_q;

	logic [1:0]  ctrl_m_q;
	logic        ctrl_s_q;
	logic        sda_out_q;
	logic        ot_warn_flag_q;
	logic        ut_warn_flag_q;
	logic        ut_fault_flag_q;
	logic        oe_q;
	logic        latched_q;
	logic        attempt_q;

	logic [15:0] unit_cnt_q;
	logic [7:0]  units_q;
	logic [2:0]  tries_q;

	tfr_pkg::fault_state_t state_q;
	tfr_pkg::fault_state_t state_d;

	smbus_target bus (
		.clk      (clk),
		.rst      (rst),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_oe_n (sda_oe_n),
		.wr_valid (wr_valid),
		.wr_cmd   (wr_cmd),
		.wr_data  (wr_data),
		.wr_len   (wr_len),
		.rd_word  (rd_word)
	);

	// Command decode; thresholds take only whole words, the action only a byte
	wire wr_word    = wr_valid && wr_len == tfr_pkg::LEN_WORD;
	wire wr_byte    = wr_valid && wr_len == tfr_pkg::LEN_BYTE;
	wire wr_ot_warn = wr_word && wr_cmd == tfr_pkg::CMD_OT_WARN_LIM;
	wire wr_ut_warn = wr_word && wr_cmd == tfr_pkg::CMD_UT_WARN_LIM;
	wire wr_ut_flt  = wr_word && wr_cmd == tfr_pkg::CMD_UT_FAULT_LIM;
	wire wr_action  = wr_byte && wr_cmd == tfr_pkg::CMD_UT_FAULT_ACT;
	wire clear_cmd  = wr_valid && wr_len == tfr_pkg::LEN_SEND
	                  && wr_cmd == tfr_pkg::CMD_CLEAR_FAULTS;

	// Read mux; unknown commands read as zero
	wire sel_ot  = wr_cmd == tfr_pkg::CMD_OT_WARN_LIM;
	wire sel_utw = wr_cmd == tfr_pkg::CMD_UT_WARN_LIM;
	wire sel_utf = wr_cmd == tfr_pkg::CMD_UT_FAULT_LIM;
	wire sel_act = wr_cmd == tfr_pkg::CMD_UT_FAULT_ACT;
	assign rd_word = sel_ot  ? ot_warn_q :
	                 sel_utw ? ut_warn_q :
	                 sel_utf ? ut_fault_lim_q :
	                 sel_act ? {8'h00, action_q} :
	                 16'h0000;

	// Action byte fields
	wire [1:0] resp  = action_q[tfr_pkg::RESP_HI:tfr_pkg::RESP_LO];
	wire [2:0] retry = action_q[tfr_pkg::RETRY_HI:tfr_pkg::RETRY_LO];
	wire [2:0] dcode = action_q[tfr_pkg::DELAY_HI:tfr_pkg::DELAY_LO];

	// Limits compared in fixed point so mixed exponents still order correctly
	wire signed [47:0] temp_fix = tfr_pkg::lin_to_fix(temp_reading);
	wire signed [47:0] otw_fix  = tfr_pkg::lin_to_fix(ot_warn_q);
	wire signed [47:0] utw_fix  = tfr_pkg::lin_to_fix(ut_warn_q);
	wire signed [47:0] utf_fix  = tfr_pkg::lin_to_fix(ut_fault_lim_q);
	wire ot_warn_c  = temp_fix > otw_fix;
	wire ut_warn_c  = temp_fix < utw_fix;
	wire ut_fault_c = temp_fix < utf_fix;

	// Output allowed only while both pin and command say on
	wire enabled    = ctrl_s_q && operation_on;
	wire user_clear = clear_cmd || status_bit_clear;
	wire fault      = ut_fault_flag_q;

	// Delay timer: unit length from the timing input, count 2^code units
	wire [15:0] unit_last  = (delay_unit_cycles == 16'h0000) ? 16'h0000
	                         : delay_unit_cycles - 16'h0001;
	wire [7:0]  units_last = (8'h01 << dcode) - 8'h01;
	wire        timing     = state_q == tfr_pkg::ST_RIDE
	                         || state_q == tfr_pkg::ST_WAIT;
	wire        unit_tick  = unit_cnt_q >= unit_last;
	wire        delay_done = timing && unit_tick && units_q == units_last;

	// Attempt outcome at the end of each wait
	wire attempt     = state_q == tfr_pkg::ST_WAIT && delay_done;
	wire tries_spent = retry != tfr_pkg::RETRY_FOREVER
	                   && (tries_q + 3'h1) >= retry;
	wire attempt_bad = attempt && fault;
	wire timer_clr   = state_d != state_q || attempt_bad;

	// Entry after a fault decision, shared by ride-through end and immediate disable
	wire [2:0] no_retry_go = (retry == tfr_pkg::RETRY_NONE) ? 3'h1 : 3'h0;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			tfr_pkg::ST_OFF: begin
				if (enabled)
					state_d = tfr_pkg::ST_RUN;
			end
			tfr_pkg::ST_RUN: begin
				if (fault) begin
					unique case (resp)
						tfr_pkg::RESP_IGNORE: state_d = tfr_pkg::ST_RUN;
						tfr_pkg::RESP_RIDE:   state_d = tfr_pkg::ST_RIDE;
						tfr_pkg::RESP_RETRY:  state_d = no_retry_go[0]
						                      ? tfr_pkg::ST_LATCH
						                      : tfr_pkg::ST_WAIT;
						tfr_pkg::RESP_LATCH:  state_d = tfr_pkg::ST_LATCH;
					endcase
				end
			end
			tfr_pkg::ST_RIDE: begin
				if (!fault)
					state_d = tfr_pkg::ST_RUN;
				else if (delay_done)
					state_d = no_retry_go[0] ? tfr_pkg::ST_LATCH
					          : tfr_pkg::ST_WAIT;
			end
			tfr_pkg::ST_WAIT: begin
				if (attempt && !fault)
					state_d = tfr_pkg::ST_RUN;
				else if (attempt_bad && tries_spent)
					state_d = tfr_pkg::ST_LATCH;
				else if (user_clear)
					state_d = tfr_pkg::ST_RUN;
			end
			tfr_pkg::ST_LATCH: begin
				if (user_clear)
					state_d = tfr_pkg::ST_RUN;
			end
		endcase
		// Turning off ends everything, including endless retry
		if (other_fault_shutdown && state_q != tfr_pkg::ST_OFF)
			state_d = tfr_pkg::ST_LATCH;
		if (!enabled)
			state_d = tfr_pkg::ST_OFF;
	end

	// Registers; reset clears any latched fault as well
	always_ff @(posedge clk) begin
		if (rst) begin
			ot_warn_q      <= tfr_pkg::RST_OT_WARN;
			ut_warn_q      <= tfr_pkg::RST_UT_WARN;
			ut_fault_lim_q <= tfr_pkg::RST_UT_FAULT;
			action_q       <= tfr_pkg::RST_UT_ACTION;
		end else begin
			if (wr_ot_warn)
				ot_warn_q <= wr_data;
			if (wr_ut_warn)
				ut_warn_q <= wr_data;
			if (wr_ut_flt)
				ut_fault_lim_q <= wr_data;
			if (wr_action)
				action_q <= wr_data[7:0];
		end
	end

	// Control pin crosses three flops before use
	always_ff @(posedge clk) begin
		ctrl_m_q <= {ctrl_m_q[0], ctrl_pin};
		ctrl_s_q <= ctrl_m_q[1];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ot_warn_flag_q  <= 1'b0;
			ut_warn_flag_q  <= 1'b0;
			ut_fault_flag_q <= 1'b0;
		end else begin
			ot_warn_flag_q  <= ot_warn_c;
			ut_warn_flag_q  <= ut_warn_c;
			ut_fault_flag_q <= ut_fault_c;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			state_q <= tfr_pkg::ST_OFF;
		else
			state_q <= state_d;
	end

	// Delay timer; restarts on each state change and on each failed attempt
	always_ff @(posedge clk) begin
		if (rst || timer_clr || !timing) begin
			unit_cnt_q <= 16'h0000;
			units_q    <= 8'h00;
		end else if (unit_tick) begin
			unit_cnt_q <= 16'h0000;
			units_q    <= units_q + 8'h01;
		end else begin
			unit_cnt_q <= unit_cnt_q + 16'h0001;
		end
	end

	// Attempt counter, kept only while waiting to restart
	always_ff @(posedge clk) begin
		if (rst || state_q != tfr_pkg::ST_WAIT)
			tries_q <= 3'h0;
		else if (attempt_bad && tries_q != 3'h7)
			tries_q <= tries_q + 3'h1;
	end

	// Output stays on during ride-through, off while waiting or latched
	wire oe_d = state_d == tfr_pkg::ST_RUN || state_d == tfr_pkg::ST_RIDE;

	always_ff @(posedge clk) begin
		if (rst) begin
			oe_q      <= 1'b0;
			latched_q <= 1'b0;
			attempt_q <= 1'b0;
			sda_out_q <= 1'b0;
		end else begin
			oe_q      <= oe_d;
			latched_q <= state_d == tfr_pkg::ST_LATCH;
			attempt_q <= attempt;
			sda_out_q <= 1'b0;
		end
	end

	assign sda_out         = sda_out_q;
	assign output_enable   = oe_q;
	assign ot_warning      = ot_warn_flag_q;
	assign ut_warning      = ut_warn_flag_q;
	assign ut_fault        = ut_fault_flag_q;
	assign fault_latched   = latched_q;
	assign restart_attempt = attempt_q;
endmodule

// ===== temp_fault_response_props.sv
`timescale 1ns/1ns
module temp_fault_response_props (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Inputs
	input wire logic [15:0] delay_unit_cycles,
	input wire logic        ctrl_pin,
	input wire logic        operation_on,
	input wire logic        status_bit_clear,
	input wire logic        other_fault_shutdown,
	// Status
	input wire logic        output_enable,
	input wire logic        ot_warning,
	input wire logic        ut_fault,
	input wire logic        fault_latched,
	input wire logic        restart_attempt
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Converter allowed to run, nothing else forcing it down
	logic run_ok;
	assign run_ok = ctrl_pin && operation_on && !other_fault_shutdown;

	AST_ATTEMPT_WHILE_OFF: assert property (restart_attempt |-> !$past(output_enable))
		else $error("restart attempt while output was on");
	AST_LATCH_HOLDS_OFF: assert property (fault_latched |-> !output_enable)
		else $error("output on while latched off");
	AST_NO_RETRY_LATCHED: assert property (fault_latched ##1 fault_latched |-> !restart_attempt)
		else $error("restart attempt while latched");
	AST_RESET_CLEARS: assert property ($fell(rst) |-> !fault_latched && !output_enable)
		else $error("state not cleared by reset");
	AST_OP_OFF_WINS: assert property (!operation_on [*3] |-> !output_enable)
		else $error("output on while commanded off");
	// Pin goes through a synchroniser, so allow for its lag
	AST_PIN_OFF_WINS: assert property (!ctrl_pin [*6] |-> !output_enable)
		else $error("output on while pin is off");
	AST_BIT_CLEAR: assert property (status_bit_clear && fault_latched && run_ok |-> ##[1:3] !fault_latched)
		else $error("bit clear did not release latch");
	AST_OTHER_SHUT: assert property (other_fault_shutdown && output_enable && ctrl_pin && operation_on
		|-> ##[1:3] fault_latched)
		else $error("other fault did not shut down");
	AST_SPACING_MIN: assert property (restart_attempt && delay_unit_cycles >= 16'h0003
		|=> !restart_attempt [*2])
		else $error("restart attempts too close");
	AST_GOOD_RESTART: assert property (restart_attempt && !ut_fault && !$past(ut_fault) && run_ok
		|-> ##[0:2] output_enable)
		else $error("good restart left output off");

	cover property (restart_attempt);
	cover property ($rose(fault_latched));
	cover property ($fell(fault_latched));
	cover property ($rose(ot_warning));
endmodule

bind temp_fault_response temp_fault_response_props u_props (
	.clk, .rst, .delay_unit_cycles, .ctrl_pin, .operation_on, .status_bit_clear,
	.other_fault_shutdown, .output_enable, .ot_warning, .ut_fault, .fault_latched, .restart_attempt
);

// ===== temp_fault_response_tb_top.sv
`timescale 1ns/1ns
module temp_fault_response_tb_top;
	logic clk, rst, scl, sda_h, ctrl_pin, operation_on, status_bit_clear, other_fault_shutdown;
	logic [15:0] temp_reading, delay_unit_cycles, d;
	logic sda_out, sda_oe_n, output_enable, ot_warning, ut_warning, ut_fault;
	logic fault_latched, restart_attempt;
	wire logic sda_line = sda_h & (sda_oe_n | sda_out);
	int fails, samples_checked, cnt, gap, last;
	logic [7:0] cmds [4] = '{8'h51, 8'h52, 8'h53, 8'h54};
	logic [15:0] rstv [4] = '{tfr_pkg::RST_OT_WARN, tfr_pkg::RST_UT_WARN,
		tfr_pkg::RST_UT_FAULT, {8'h00, tfr_pkg::RST_UT_ACTION}};
	logic [15:0] newv [4] = '{16'h0032, 16'h000a, 16'h0000, 16'h0000};
	logic [15:0] temps [4] = '{16'h0014, 16'h003c, 16'h0005, 16'h07fb};
	logic [15:0] flags [4] = '{16'h0000, 16'h0004, 16'h0002, 16'h0003};
	logic [7:0] acts [7] = '{8'h00, 8'hd0, 8'h91, 8'h80, 8'h41, 8'hb9, 8'h92};
	logic [15:0] units [7] = '{16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'h0};
	int ex_att [7] = '{0, 0, 2, 0, 0, 8, 2};
	int ex_gap [7] = '{0, 0, 6, 0, 0, 6, 4};
	logic ex_lat [7] = '{0, 1, 1, 1, 1, 0, 1};

	temp_fault_response u_dut (
		.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .temp_reading(temp_reading), .delay_unit_cycles(delay_unit_cycles),
		.ctrl_pin(ctrl_pin), .operation_on(operation_on), .status_bit_clear(status_bit_clear),
		.other_fault_shutdown(other_fault_shutdown), .output_enable(output_enable),
		.ot_warning(ot_warning), .ut_warning(ut_warning), .ut_fault(ut_fault),
		.fault_latched(fault_latched), .restart_attempt(restart_attempt)
	);
	smbus_host_model u_host (.clk(clk), .scl(scl), .sda(sda_h), .sda_line(sda_line));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		temp_reading = 16'h0014;
		delay_unit_cycles = 16'h0003;
		ctrl_pin = 1'b1;
		operation_on = 1'b1;
		status_bit_clear = 1'b0;
		other_fault_shutdown = 1'b0;
		wt(8);
		rst <= 1'b0;
		wt(8);
		for (int i = 0; i < 4; i++) begin
			u_host.rd(cmds[i], i == 3 ? tfr_pkg::LEN_BYTE : tfr_pkg::LEN_WORD, d);
			cmp(d, rstv[i]);
			u_host.wr(cmds[i], newv[i], i == 3 ? tfr_pkg::LEN_BYTE : tfr_pkg::LEN_WORD);
			u_host.rd(cmds[i], i == 3 ? tfr_pkg::LEN_BYTE : tfr_pkg::LEN_WORD, d);
			cmp(d, newv[i]);
		end
		u_host.rd(8'h60, tfr_pkg::LEN_WORD, d);
		cmp(d, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			temp_reading <= temps[i];
			wt(4);
			cmp({13'h0, ot_warning, ut_warning, ut_fault}, flags[i]);
		end
		temp_reading <= 16'h0014;
		wt(20);
		for (int i = 0; i < 7; i++) begin
			delay_unit_cycles <= units[i];
			u_host.wr(tfr_pkg::CMD_UT_FAULT_ACT, {8'h00, acts[i]}, tfr_pkg::LEN_BYTE);
			temp_reading <= 16'h07fb;
			wt(5);
			cmp({15'h0, acts[i][7:6] <= tfr_pkg::RESP_RIDE}, {15'h0, output_enable});
			cnt = 0;
			gap = 0;
			last = 0;
			for (int c = 0; c < 120; c++) begin
				wt(1);
				if (restart_attempt === 1'b1) begin
					if (cnt > 0) gap = c - last;
					last = c;
					cnt++;
				end
			end
			cmp(16'(cnt > 8 ? 8 : cnt), 16'(ex_att[i]));
			if (cnt > 1) cmp(16'(gap), 16'(ex_gap[i]));
			temp_reading <= 16'h0014;
			wt(20);
			cmp({15'h0, fault_latched}, {15'h0, ex_lat[i]});
			cmp({15'h0, output_enable}, {15'h0, !ex_lat[i]});
			if (acts[i] == 8'hb9) begin
				other_fault_shutdown <= 1'b1;
				wt(1);
				other_fault_shutdown <= 1'b0;
				wt(5);
				cmp({15'h0, fault_latched}, 16'h0001);
			end
			// Rotate through the ways a latched fault can be released
			case (i % 4)
				0: u_host.wr(tfr_pkg::CMD_CLEAR_FAULTS, 16'h0000, tfr_pkg::LEN_SEND);
				1: begin
					status_bit_clear <= 1'b1;
					wt(1);
					status_bit_clear <= 1'b0;
				end
				2: begin
					ctrl_pin <= 1'b0;
					wt(10);
					ctrl_pin <= 1'b1;
				end
				default: begin
					operation_on <= 1'b0;
					wt(10);
					operation_on <= 1'b1;
				end
			endcase
			wt(20);
			cmp({15'h0, fault_latched}, 16'h0000);
			cmp({15'h0, output_enable}, 16'h0001);
		end
		// Reset in mid-run must drop a latched fault; temperature is normal by release
		u_host.wr(tfr_pkg::CMD_UT_FAULT_ACT, 16'h00c0, tfr_pkg::LEN_BYTE);
		temp_reading <= 16'h07fb;
		wt(10);
		cmp({15'h0, fault_latched}, 16'h0001);
		rst <= 1'b1;
		temp_reading <= 16'h0014;
		wt(8);
		rst <= 1'b0;
		cmp({15'h0, fault_latched}, 16'h0000);
		wt(12);
		cmp({15'h0, output_enable}, 16'h0001);
		cmp(16'(u_host.nak_cnt), 16'h0000);
		test_done();
	end
endmodule

// ===== tfr_pkg.sv
package tfr_pkg;

	// Command codes
	localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
	localparam logic [7:0] CMD_OT_WARN_LIM   = 8'h51;
	localparam logic [7:0] CMD_UT_WARN_LIM   = 8'h52;
	localparam logic [7:0] CMD_UT_FAULT_LIM  = 8'h53;
	localparam logic [7:0] CMD_UT_FAULT_ACT  = 8'h54;

	// Bus target address, arbitrary
	localparam logic [6:0] TARGET_ADDR       = 7'h2a;

	// Reset values: +85, -40 and -45 degrees, exponent zero
	localparam logic [15:0] RST_OT_WARN      = 16'h0055;
	localparam logic [15:0] RST_UT_WARN      = 16'h07d8;
	localparam logic [15:0] RST_UT_FAULT     = 16'h07d3;
	localparam logic [7:0]  RST_UT_ACTION    = 8'h80;

	// Action byte fields
	localparam int RESP_HI  = 7;
	localparam int RESP_LO  = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DELAY_HI = 2;
	localparam int DELAY_LO = 0;

	localparam logic [1:0] RESP_IGNORE   = 2'h0;
	localparam logic [1:0] RESP_RIDE     = 2'h1;
	localparam logic [1:0] RESP_RETRY    = 2'h2;
	localparam logic [1:0] RESP_LATCH    = 2'h3;
	localparam logic [2:0] RETRY_NONE    = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// Transfer lengths after the command byte
	localparam logic [1:0] LEN_SEND = 2'h0;
	localparam logic [1:0] LEN_BYTE = 2'h1;
	localparam logic [1:0] LEN_WORD = 2'h2;

	typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_RIDE, ST_WAIT, ST_LATCH} fault_state_t;
	typedef enum logic [2:0] {BS_IDLE, BS_RX, BS_ACK, BS_TX, BS_TXACK} bus_state_t;

	// Linear value to signed fixed point with 16 fraction bits
	function automatic logic signed [47:0] lin_to_fix(input logic [15:0] v);
		logic signed [47:0] m;
		logic [4:0]         sh;
		m  = {{37{v[10]}}, v[10:0]};
		sh = {~v[15], v[14:11]};
		return m <<< sh;
	endfunction

endpackage
